// [inc/cc_port_consts.svh]
`ifndef CC_PORT_CONSTS_SVH
`define CC_PORT_CONSTS_SVH

// Serial target addresses chosen by the bus-select strap
`define DEV_ADDR_HI     7'h67
`define DEV_ADDR_LO     7'h47

// Register indices
`define REG_STATUS      4'h0
`define REG_CTRL        4'h1
`define REG_INT_STATUS  4'h2
`define REG_INT_CLEAR   4'h3
`define REG_INT_ENABLE  4'h4
`define REG_ROLE        4'h5

// Control register fields
`define CTRL_SOFT_RST   0
`define CTRL_OVR_EN     1
`define CTRL_ROLE_LSB   2
`define CTRL_ADV_LSB    4
`define CTRL_RST_VAL    8'h00
`define CTRL_KEEP_MASK  8'h3e

// Event bits
`define EV_ATTACH       0
`define EV_DETACH       1
`define EV_AUDIO        2
`define EV_CURRENT      3
`define INT_EN_RST_VAL  8'h00

// Timing
`define CLK_MHZ         200
`define DRP_HALF_US     35
`define CC_DEBOUNCE_US  150

`endif

// [inc/cc_port_pkg.sv]
package cc_port_pkg;

	typedef enum logic [1:0] {STRAP_LOW, STRAP_HIGH, STRAP_OPEN} strap_t;
	typedef enum logic [1:0] {ROLE_SNK, ROLE_SRC, ROLE_DRP} role_t;
	typedef enum logic [1:0] {CUR_NONE, CUR_DEF, CUR_MED, CUR_HIGH} cur_t;
	typedef enum logic [2:0] {
		ST_UNATT_SRC, ST_UNATT_SNK, ST_WAIT_SRC, ST_WAIT_SNK,
		ST_ATT_SRC, ST_ATT_SNK, ST_AUDIO
	} fsm_t;

	// Tri-level strap seen through two comparators
	typedef struct packed {
		logic hi;
		logic lo;
	} strap_pins_t;

	// One CC line as seen by the analog front end
	typedef struct packed {
		logic       rd;
		logic       ra;
		logic [1:0] rp;
	} cc_sense_t;

	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [6:0] dev;
		logic [3:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	// Open-drain enables: high pulls the pin low
	typedef struct packed {
		logic attach;
		logic mode_a;
		logic mode_b;
		logic audio_int;
	} od_t;

	typedef struct packed {
		logic        en_s1;
		logic        en_s2;
		strap_pins_t port_s1;
		strap_pins_t port_s2;
		strap_pins_t addr_s1;
		strap_pins_t addr_s2;
		cc_sense_t   cc1_s1;
		cc_sense_t   cc1_s2;
		cc_sense_t   cc2_s1;
		cc_sense_t   cc2_s2;
		logic        vbus_s1;
		logic        vbus_s2;
		logic        was_en;
		role_t       role;
		strap_t      busmode;
		fsm_t        fsm;
		logic [23:0] cnt;
		logic        orient;
		cur_t        cur;
		logic [7:0]  ctrl;
		logic [7:0]  int_st;
		logic [7:0]  int_en;
		logic [7:0]  rdata;
	} state_t;

endpackage

// [logic/cc_port_ctrl.sv]
// Our own choices: the address-and-strobe port and the register addresses.
`include "cc_port_consts.svh"

module cc_port_ctrl #(
	parameter int unsigned DRP_HALF_CYC = `DRP_HALF_US * `CLK_MHZ,
	parameter int unsigned DEBOUNCE_CYC = `CC_DEBOUNCE_US * `CLK_MHZ
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   sys_rst,
	// Pins from outside the clock domain
	input  wire logic                   en_n,
	input  wire cc_port_pkg::strap_pins_t port_strap,
	input  wire cc_port_pkg::strap_pins_t bus_strap,
	input  wire cc_port_pkg::cc_sense_t cc1_sense,
	input  wire cc_port_pkg::cc_sense_t cc2_sense,
	input  wire logic                   bus_power_sense,
	// Analog front end control
	output logic                        cc_pullup_en,
	output logic                        cc_pulldown_en,
	output logic [1:0]                  cc_adv_level,
	// Open-drain pin enables
	output cc_port_pkg::od_t            od_oe,
	// Register port behind the serial engine
	input  wire cc_port_pkg::bus_req_t  req,
	output logic [7:0]                  rdata,
	output logic                        irq
);

	cc_port_pkg::state_t st_r;
	cc_port_pkg::state_t st_nxt;

	logic                 en;
	logic                 serial;
	logic                 capture;
	logic                 soft_rst;
	logic                 hit;
	logic                 wr_hit;
	logic                 rd_hit;
	logic [6:0]           sel_addr;
	logic [7:0]           clr;
	logic [7:0]           ev;
	logic [7:0]           status;
	logic                 src_seen;
	logic                 snk_seen;
	logic                 audio_seen;
	logic                 drp_flip;
	logic                 debounced;
	cc_port_pkg::role_t   eff_role;
	cc_port_pkg::cc_sense_t act_cc;

	function automatic cc_port_pkg::strap_t decode_strap(cc_port_pkg::strap_pins_t p);
		if (p.hi && !p.lo) begin
			return cc_port_pkg::STRAP_HIGH;
		end else if (p.lo && !p.hi) begin
			return cc_port_pkg::STRAP_LOW;
		end
		return cc_port_pkg::STRAP_OPEN;
	endfunction

	function automatic cc_port_pkg::role_t strap_role(cc_port_pkg::strap_pins_t p);
		case (decode_strap(p))
			cc_port_pkg::STRAP_HIGH: return cc_port_pkg::ROLE_SRC;
			cc_port_pkg::STRAP_LOW:  return cc_port_pkg::ROLE_SNK;
			default:                 return cc_port_pkg::ROLE_DRP;
		endcase
	endfunction

	function automatic cc_port_pkg::fsm_t home(cc_port_pkg::role_t r);
		return (r == cc_port_pkg::ROLE_SNK) ? cc_port_pkg::ST_UNATT_SNK
			: cc_port_pkg::ST_UNATT_SRC;
	endfunction

	function automatic logic is_att(cc_port_pkg::fsm_t f);
		return f == cc_port_pkg::ST_ATT_SRC || f == cc_port_pkg::ST_ATT_SNK
			|| f == cc_port_pkg::ST_AUDIO;
	endfunction

	// enable is active low, pulled up when idle
	assign en      = !st_r.en_s2;
	assign capture = en && !st_r.was_en;

	// serial address follows the bus strap
	assign serial   = st_r.busmode != cc_port_pkg::STRAP_OPEN;
	assign sel_addr = (st_r.busmode == cc_port_pkg::STRAP_HIGH) ? `DEV_ADDR_HI
		: `DEV_ADDR_LO;
	assign hit      = en && serial && req.dev == sel_addr;
	assign wr_hit   = hit && req.wr;
	assign rd_hit   = hit && req.rd;
	assign soft_rst = wr_hit && req.addr == `REG_CTRL && req.wdata[`CTRL_SOFT_RST];
	assign clr      = (wr_hit && req.addr == `REG_INT_CLEAR) ? req.wdata : 8'h00;

	// serial override of the strapped role
	always_comb begin
		eff_role = st_r.role;
		if (serial && st_r.ctrl[`CTRL_OVR_EN]) begin
			case (st_r.ctrl[`CTRL_ROLE_LSB +: 2])
				2'h0:    eff_role = cc_port_pkg::ROLE_SNK;
				2'h1:    eff_role = cc_port_pkg::ROLE_SRC;
				default: eff_role = cc_port_pkg::ROLE_DRP;
			endcase
		end
	end

	// line detection on both CC pins
	assign src_seen   = st_r.cc1_s2.rd || st_r.cc2_s2.rd;
	assign audio_seen = st_r.cc1_s2.ra && st_r.cc2_s2.ra;
	assign snk_seen   = st_r.cc1_s2.rp != 2'h0 || st_r.cc2_s2.rp != 2'h0;
	assign act_cc     = st_r.orient ? st_r.cc2_s2 : st_r.cc1_s2;
	assign drp_flip   = eff_role == cc_port_pkg::ROLE_DRP
		&& st_r.cnt >= 24'(DRP_HALF_CYC);
	assign debounced  = st_r.cnt >= 24'(DEBOUNCE_CYC);

	assign status = {1'b0, st_r.vbus_s2, st_r.fsm == cc_port_pkg::ST_AUDIO, st_r.cur,
		st_r.orient, st_r.fsm == cc_port_pkg::ST_ATT_SRC, is_att(st_r.fsm)};

	always_comb begin
		st_nxt = st_r;
		ev = 8'h00;
		st_nxt.en_s1   = en_n;
		st_nxt.en_s2   = st_r.en_s1;
		st_nxt.port_s1 = port_strap;
		st_nxt.port_s2 = st_r.port_s1;
		st_nxt.addr_s1 = bus_strap;
		st_nxt.addr_s2 = st_r.addr_s1;
		st_nxt.cc1_s1  = cc1_sense;
		st_nxt.cc1_s2  = st_r.cc1_s1;
		st_nxt.cc2_s1  = cc2_sense;
		st_nxt.cc2_s2  = st_r.cc2_s1;
		st_nxt.vbus_s1 = bus_power_sense;
		st_nxt.vbus_s2 = st_r.vbus_s1;
		st_nxt.was_en  = en;
		st_nxt.cnt     = st_r.cnt + 24'h1;
		st_nxt.rdata   = 8'h00;

		case (st_r.fsm)
			cc_port_pkg::ST_UNATT_SRC: begin
				// restart lands here; a sink role moves on
				if (eff_role == cc_port_pkg::ROLE_SNK) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SNK;
					st_nxt.cnt = 24'h0;
				end else if (src_seen || audio_seen) begin
					st_nxt.fsm = cc_port_pkg::ST_WAIT_SRC;
					st_nxt.cnt = 24'h0;
				end else if (drp_flip) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SNK;
					st_nxt.cnt = 24'h0;
				end
			end
			cc_port_pkg::ST_UNATT_SNK: begin
				// a source role never waits as sink
				if (eff_role == cc_port_pkg::ROLE_SRC) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SRC;
					st_nxt.cnt = 24'h0;
				end else if (snk_seen) begin
					st_nxt.fsm = cc_port_pkg::ST_WAIT_SNK;
					st_nxt.cnt = 24'h0;
				end else if (drp_flip) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SRC;
					st_nxt.cnt = 24'h0;
				end
			end
			cc_port_pkg::ST_WAIT_SRC: begin
				if (!src_seen && !audio_seen) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SRC;
					st_nxt.cnt = 24'h0;
				end else if (debounced) begin
					st_nxt.fsm    = audio_seen ? cc_port_pkg::ST_AUDIO
						: cc_port_pkg::ST_ATT_SRC;
					st_nxt.orient = !st_r.cc1_s2.rd;
				end
			end
			cc_port_pkg::ST_WAIT_SNK: begin
				if (!snk_seen) begin
					st_nxt.fsm = cc_port_pkg::ST_UNATT_SNK;
					st_nxt.cnt = 24'h0;
				// bus power confirms the sink attach
				end else if (debounced && st_r.vbus_s2) begin
					st_nxt.fsm    = cc_port_pkg::ST_ATT_SNK;
					st_nxt.orient = st_r.cc1_s2.rp == 2'h0;
					// Level valid from the first attached cycle, no pin glitch
					st_nxt.cur    = cc_port_pkg::cur_t'(st_r.cc1_s2.rp | st_r.cc2_s2.rp);
				end
			end
			cc_port_pkg::ST_ATT_SRC: begin
				if (!act_cc.rd) begin
					st_nxt.fsm = home(eff_role);
					st_nxt.cnt = 24'h0;
				end
			end
			cc_port_pkg::ST_ATT_SNK: begin
				st_nxt.cur = cc_port_pkg::cur_t'(act_cc.rp);
				if (!st_r.vbus_s2) begin
					st_nxt.fsm = home(eff_role);
					st_nxt.cnt = 24'h0;
					st_nxt.cur = cc_port_pkg::CUR_NONE;
				end
			end
			cc_port_pkg::ST_AUDIO: begin
				if (!audio_seen) begin
					st_nxt.fsm = home(eff_role);
					st_nxt.cnt = 24'h0;
				end
			end
			default: begin
				st_nxt.fsm = home(eff_role);
			end
		endcase

		ev[`EV_ATTACH]  = is_att(st_nxt.fsm) && !is_att(st_r.fsm);
		ev[`EV_DETACH]  = !is_att(st_nxt.fsm) && is_att(st_r.fsm);
		ev[`EV_AUDIO]   = st_nxt.fsm == cc_port_pkg::ST_AUDIO
			&& st_r.fsm != cc_port_pkg::ST_AUDIO;
		ev[`EV_CURRENT] = st_nxt.cur != st_r.cur;
		// Set beats a clear in the same cycle
		st_nxt.int_st = (st_r.int_st & ~clr) | ev;

		if (wr_hit) begin
			case (req.addr)
				`REG_CTRL: begin
					// A role change restarts detection from scratch
					st_nxt.ctrl = req.wdata & `CTRL_KEEP_MASK;
					st_nxt.fsm  = cc_port_pkg::ST_UNATT_SRC;
					st_nxt.cnt  = 24'h0;
				end
				`REG_INT_ENABLE: begin
					st_nxt.int_en = req.wdata;
				end
				default: begin
				end
			endcase
		end
		if (rd_hit) begin
			case (req.addr)
				`REG_STATUS:     st_nxt.rdata = status;
				`REG_CTRL:       st_nxt.rdata = st_r.ctrl;
				`REG_INT_STATUS: st_nxt.rdata = st_r.int_st;
				`REG_INT_ENABLE: st_nxt.rdata = st_r.int_en;
				`REG_ROLE:       st_nxt.rdata = {4'h0, 2'(eff_role), 2'(st_r.role)};
				default:         st_nxt.rdata = 8'h00;
			endcase
		end

		// port strap captured at enable and soft reset, bus strap at enable only
		if (capture || soft_rst) begin
			st_nxt.role = strap_role(st_r.port_s2);
			st_nxt.cnt  = 24'h0;
			st_nxt.cur  = cc_port_pkg::CUR_NONE;
			if (capture) begin
				st_nxt.busmode = decode_strap(st_r.addr_s2);
				st_nxt.ctrl    = `CTRL_RST_VAL;
				st_nxt.int_en  = `INT_EN_RST_VAL;
				st_nxt.int_st  = 8'h00;
			end
			st_nxt.fsm = (strap_role(st_r.port_s2) == cc_port_pkg::ROLE_SNK)
				? cc_port_pkg::ST_UNATT_SNK : cc_port_pkg::ST_UNATT_SRC;
		end
		if (!en) begin
			st_nxt.fsm    = cc_port_pkg::ST_UNATT_SRC;
			st_nxt.cnt    = 24'h0;
			st_nxt.cur    = cc_port_pkg::CUR_NONE;
			st_nxt.int_st = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r       <= '0;
			st_r.en_s1 <= 1'b1;
			st_r.en_s2 <= 1'b1;
			st_r.ctrl  <= `CTRL_RST_VAL;
			st_r.int_en <= `INT_EN_RST_VAL;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign cc_adv_level   = (st_r.ctrl[`CTRL_ADV_LSB +: 2] == 2'h0) ? 2'h1
		: st_r.ctrl[`CTRL_ADV_LSB +: 2];
	assign cc_pullup_en   = en && (st_r.fsm == cc_port_pkg::ST_UNATT_SRC
		|| st_r.fsm == cc_port_pkg::ST_WAIT_SRC || st_r.fsm == cc_port_pkg::ST_ATT_SRC
		|| st_r.fsm == cc_port_pkg::ST_AUDIO);
	assign cc_pulldown_en = en && (st_r.fsm == cc_port_pkg::ST_UNATT_SNK
		|| st_r.fsm == cc_port_pkg::ST_WAIT_SNK || st_r.fsm == cc_port_pkg::ST_ATT_SNK);
	assign irq            = en && serial && |(st_r.int_st & st_r.int_en);
	assign rdata          = st_r.rdata;

	// attach flag only while enabled source sees a sink
	assign od_oe.attach    = en && st_r.fsm == cc_port_pkg::ST_ATT_SRC;
	assign od_oe.mode_a    = en && !serial && st_r.fsm == cc_port_pkg::ST_ATT_SNK
		&& st_r.cur != cc_port_pkg::CUR_DEF;
	assign od_oe.mode_b    = en && !serial && st_r.fsm == cc_port_pkg::ST_ATT_SNK
		&& st_r.cur == cc_port_pkg::CUR_HIGH;
	assign od_oe.audio_int = serial ? irq
		: (en && st_r.fsm == cc_port_pkg::ST_AUDIO);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_role_capture: assert property ((!st_r.en_s2 && !st_r.was_en)
		|=> st_r.role == strap_role($past(st_r.port_s2)))
		else $error("role not captured at enable");
	a_soft_recapture: assert property (soft_rst && st_r.was_en
		|=> st_r.role == strap_role($past(st_r.port_s2)))
		else $error("role not captured at soft reset");
	a_strap_decode: assert property ((st_r.port_s2.hi && !st_r.port_s2.lo)
		##1 (!st_r.en_s2 && !st_r.was_en) |=> st_r.role == cc_port_pkg::ROLE_SRC)
		else $error("high strap not decoded as source");
	a_addr_hi: assert property ((en && st_r.busmode == cc_port_pkg::STRAP_HIGH
		&& req.rd && req.dev == `DEV_ADDR_HI && req.addr == `REG_CTRL)
		|=> rdata == $past(st_r.ctrl))
		else $error("no answer at high address");
	a_addr_lo: assert property ((st_r.busmode == cc_port_pkg::STRAP_LOW
		&& req.rd && req.dev != `DEV_ADDR_LO) |=> rdata == 8'h00)
		else $error("answered wrong address");
	a_no_serial: assert property ((st_r.busmode == cc_port_pkg::STRAP_OPEN
		&& req.wr) |=> $stable(st_r.int_en))
		else $error("write taken without serial");
	a_int_pin: assert property ((en && serial)
		|-> od_oe.audio_int == |(st_r.int_st & st_r.int_en))
		else $error("interrupt pin wrong");
	a_audio_pin: assert property ((en && !serial)
		|-> od_oe.audio_int == (st_r.fsm == cc_port_pkg::ST_AUDIO))
		else $error("audio pin wrong");
	a_mode_a_pin: assert property ((en && !serial && st_r.fsm == cc_port_pkg::ST_ATT_SNK)
		|-> od_oe.mode_a == (st_r.cur != cc_port_pkg::CUR_DEF))
		else $error("mode A pin wrong");
	a_mode_b_pin: assert property ((en && !serial && st_r.fsm == cc_port_pkg::ST_ATT_SNK)
		|-> od_oe.mode_b == (st_r.cur == cc_port_pkg::CUR_HIGH))
		else $error("mode B pin wrong");
	a_snk_vbus: assert property ((st_r.fsm == cc_port_pkg::ST_ATT_SNK
		&& $past(st_r.fsm) == cc_port_pkg::ST_WAIT_SNK) |-> $past(st_r.vbus_s2))
		else $error("sink attached without bus power");
	a_drp_toggle: assert property ((en && st_r.was_en && !soft_rst && !wr_hit
		&& st_r.fsm == cc_port_pkg::ST_UNATT_SRC && !src_seen && !audio_seen && drp_flip)
		|=> st_r.fsm == cc_port_pkg::ST_UNATT_SNK)
		else $error("dual role did not toggle");
	a_off_release: assert property (st_r.en_s2 |-> od_oe == '0)
		else $error("pin driven while disabled");
	a_set_wins: assert property ((en && st_r.was_en && ev[`EV_ATTACH]
		&& clr[`EV_ATTACH]) |=> st_r.int_st[`EV_ATTACH])
		else $error("event lost to clear");
	a_no_serial_read: assert property ((st_r.busmode == cc_port_pkg::STRAP_OPEN
		&& req.rd) |=> rdata == 8'h00)
		else $error("read answered without serial");
	a_ovr_sink: assert property ((en && st_r.was_en && !wr_hit
		&& eff_role == cc_port_pkg::ROLE_SNK && st_r.fsm == cc_port_pkg::ST_UNATT_SRC)
		|=> st_r.fsm == cc_port_pkg::ST_UNATT_SNK)
		else $error("sink override kept source pull-up");

endmodule

// [sim/cc_partner_model.sv]
module cc_partner_model (
	// Scenario control
	input  wire logic [1:0]        mode,
	input  wire logic              flip,
	input  wire logic [1:0]        level,
	input  wire logic              vbus_on,
	// Device terminations
	input  wire logic              pullup_en,
	input  wire logic              pulldown_en,
	// Sensed lines toward the device
	output cc_port_pkg::cc_sense_t cc1,
	output cc_port_pkg::cc_sense_t cc2,
	output logic                   vbus
);
	timeunit 1ns;
	timeprecision 1ps;
	cc_port_pkg::cc_sense_t act;

	always_comb begin
		act = '0;
		act.rd = (mode == 2'h1) && pullup_en;
		act.rp = (mode == 2'h2 && pulldown_en) ? level : 2'h0;
		cc1 = flip ? '0 : act;
		cc2 = flip ? act : '0;
		// Audio plug loads both lines
		cc1.ra = (mode == 2'h3) && pullup_en;
		cc2.ra = (mode == 2'h3) && pullup_en;
	end

	assign vbus = (mode == 2'h2) && vbus_on;
endmodule

// [sim/typec_cc_port_role_control_tb.sv]
`include "cc_port_consts.svh"

module typec_cc_port_role_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DEB = 16;
	logic                     sys_clk, sys_rst, en_n, vbus, pu, pd, irq, flip, vbus_on;
	cc_port_pkg::strap_pins_t port_strap, bus_strap;
	cc_port_pkg::cc_sense_t   cc1, cc2;
	cc_port_pkg::bus_req_t    req;
	cc_port_pkg::od_t         od_oe;
	logic [1:0]               adv, pmode, plevel;
	logic [7:0]               rdata;
	logic [6:0]               dev;
	logic [7:0]               role_exp [3] = '{8'h05, 8'h00, 8'h0a};
	int                       fails, samples_checked, nu, nd;

	cc_port_ctrl #(.DRP_HALF_CYC(8), .DEBOUNCE_CYC(DEB)) cc_port_ctrl_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .en_n(en_n), .port_strap(port_strap),
		.bus_strap(bus_strap), .cc1_sense(cc1), .cc2_sense(cc2), .bus_power_sense(vbus),
		.cc_pullup_en(pu), .cc_pulldown_en(pd), .cc_adv_level(adv), .od_oe(od_oe),
		.req(req), .rdata(rdata), .irq(irq)
	);

	cc_partner_model cc_partner_model_inst (
		.mode(pmode), .flip(flip), .level(plevel), .vbus_on(vbus_on), .pullup_en(pu),
		.pulldown_en(pd), .cc1(cc1), .cc2(cc2), .vbus(vbus)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ends just past an edge so later drives stay off the sampling edge
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		req <= '{rd: 1'b0, wr: 1'b1, dev: dev, addr: a, wdata: d};
		@(posedge sys_clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input string what, input logic [3:0] a, input logic [7:0] m,
			input logic [7:0] exp);
		@(posedge sys_clk);
		req <= '{rd: 1'b1, wr: 1'b0, dev: dev, addr: a, wdata: 8'h00};
		@(posedge sys_clk);
		req.rd <= 1'b0;
		#1;
		chk(what, exp, rdata & m);
	endtask

	task automatic wait_od(input int i, input logic v);
		int k;
		for (k = 0; k < 200 && od_oe[i] !== v; k++) cyc(1);
		if (k == 200) begin
			fails++;
			$display("[FAIL] od_oe bit %0d expected %b seen %b", i, v, od_oe[i]);
			stop_test();
		end
	endtask

	// Straps settle well before the enable edge
	task automatic power(input cc_port_pkg::strap_pins_t ps, input cc_port_pkg::strap_pins_t bs);
		en_n <= 1'b1;
		cyc(3);
		port_strap <= ps;
		bus_strap <= bs;
		dev <= (bs == 2'h2) ? 7'h67 : 7'h47;
		cyc(3);
		en_n <= 1'b0;
		cyc(5);
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		fails = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		en_n = 1'b1;
		port_strap = 2'h0;
		bus_strap = 2'h1;
		req = '0;
		dev = 7'h47;
		pmode = 2'h0;
		flip = 1'b0;
		plevel = 2'h1;
		vbus_on = 1'b0;
		cyc(3);
		sys_rst <= 1'b0;
		cyc(2);
		chk("od_oe off", 8'h00, {4'h0, od_oe});
		chk("irq off", 8'h00, {7'h00, irq});
		rd("read disabled", `REG_ROLE, 8'hff, 8'h00);
		done("disabled");

		for (int k = 0; k < 3; k++) begin
			power(2'h2 >> k, 2'h1);
			rd("role", `REG_ROLE, 8'h0f, role_exp[k]);
		end
		rd("unmapped", 4'hf, 8'hff, 8'h00);
		dev <= 7'h67;
		rd("other dev", `REG_ROLE, 8'hff, 8'h00);
		power(2'h2, 2'h2);
		rd("role hi bus", `REG_ROLE, 8'h0f, 8'h05);
		dev <= 7'h47;
		rd("other dev hi", `REG_ROLE, 8'hff, 8'h00);
		dev <= 7'h67;
		port_strap <= 2'h0;
		cyc(3);
		rd("role held", `REG_ROLE, 8'h0f, 8'h05);
		wr(`REG_CTRL, 8'h01);
		cyc(3);
		rd("role soft rst", `REG_ROLE, 8'h0f, 8'h0a);
		done("straps");

		for (int k = 1; k < 4; k++) begin
			wr(`REG_CTRL, {2'h0, 2'(k), 4'h0});
			cyc(2);
			chk("adv level", {6'h00, 2'(k)}, {6'h00, adv});
		end
		wr(`REG_CTRL, 8'h02);
		rd("ovr sink", `REG_ROLE, 8'h0f, 8'h02);
		cyc(4);
		chk("terms sink", 8'h01, {6'h00, pu, pd});
		wr(`REG_CTRL, 8'h06);
		rd("ovr src", `REG_ROLE, 8'h0f, 8'h06);
		cyc(4);
		chk("terms src", 8'h02, {6'h00, pu, pd});
		chk("adv default", 8'h01, {6'h00, adv});
		done("override");

		power(2'h2, 2'h1);
		wr(`REG_INT_ENABLE, 8'h03);
		rd("int enable", `REG_INT_ENABLE, 8'hff, 8'h03);
		pmode <= 2'h1;
		flip <= 1'b1;
		cyc(10);
		chk("early attach", 8'h00, {7'h00, od_oe.attach});
		wait_od(3, 1'b1);
		rd("status", `REG_STATUS, 8'h67, 8'h07);
		chk("irq attach", 8'h01, {7'h00, irq});
		rd("int attach", `REG_INT_STATUS, 8'h0f, 8'h01);
		wr(`REG_INT_CLEAR, 8'h01);
		cyc(1);
		chk("irq cleared", 8'h00, {7'h00, irq});
		pmode <= 2'h0;
		wait_od(3, 1'b0);
		rd("int detach", `REG_INT_STATUS, 8'h0f, 8'h02);
		chk("irq detach", 8'h01, {7'h00, irq});
		wr(`REG_INT_ENABLE, 8'h00);
		cyc(1);
		chk("irq masked", 8'h00, {7'h00, irq});
		done("source attach");

		power(2'h1, 2'h0);
		wr(`REG_INT_ENABLE, 8'hff);
		cyc(1);
		chk("irq no serial", 8'h00, {7'h00, irq});
		for (int k = 1; k < 4; k++) begin
			plevel <= 2'(k);
			pmode <= 2'h2;
			cyc(DEB + 10);
			chk("no bus power", 8'h00, {4'h0, od_oe});
			vbus_on <= 1'b1;
			cyc(6);
			chk("mode pins", {5'h00, k != 1, k == 3, 1'b0}, {4'h0, od_oe});
			rd("serial off", `REG_STATUS, 8'hff, 8'h00);
			pmode <= 2'h0;
			vbus_on <= 1'b0;
			cyc(8);
		end
		done("sink status");

		power(2'h2, 2'h0);
		pmode <= 2'h3;
		cyc(DEB + 10);
		chk("audio pin", 8'h01, {4'h0, od_oe});
		en_n <= 1'b1;
		cyc(4);
		chk("released", 8'h00, {4'h0, od_oe});
		pmode <= 2'h0;
		done("audio");

		power(2'h0, 2'h1);
		nu = 0;
		nd = 0;
		for (int k = 0; k < 40; k++) begin
			cyc(1);
			nu += int'(pu === 1'b1);
			nd += int'(pd === 1'b1);
		end
		chk("drp toggle", 8'h01, {7'h00, nu > 0 && nd > 0});
		done("dual role");
		stop_test();
	end
endmodule
